// [hw/vst_pkg.sv]
// shared constants and carriers for the oscillator split and tuning control
package vst_pkg;
	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFF_CTRL = 8'h00; // level controls
	localparam logic [7:0] OFF_CMD = 8'h04; // one-shot commands
	localparam logic [7:0] OFF_RXF = 8'h08; // receive setting, hertz
	localparam logic [7:0] OFF_TXF = 8'h0c; // transmit setting, hertz
	localparam logic [7:0] OFF_FINE = 8'h10; // receive fine offset
	localparam logic [7:0] OFF_CWOFF = 8'h14; // cw shift amount
	localparam logic [7:0] OFF_STAT = 8'h18; // status
	localparam logic [7:0] OFF_LISTEN = 8'h1c; // frequency heard
	// ****************************************
	// field layout and limits
	// ****************************************
	localparam int CTRL_W = 6; // ctrl width
	localparam int CMD_W = 14; // cmd width
	localparam logic signed [15:0] FINE_MAX = 16'sh2710; // +10 kHz
	localparam logic signed [15:0] FINE_MIN = -16'sh2710; // -10 kHz
	localparam logic [3:0] HIST_DEPTH = 4'ha; // undo stack depth
	localparam logic [2:0] DEC_TOP = 3'h7; // 10 MHz decade
	localparam logic [31:0] CWOFF_RST = 32'h0000_0000; // cw shift reset
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 40_000_000; // core_clk rate
	localparam logic [7:0] RPT_HZ = 8'h14; // 20 steps per second
	localparam logic [7:0] ACC_HZ = 8'hc8; // 200 steps per second
	localparam int RAMP_S = 10; // acceleration time, seconds
	localparam int RAMP_CYC = RAMP_S * CLK_HZ / (200 - 20); // cycles per +1 step/s
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic hold_dn; // down input held
		logic hold_up; // up input held
		logic caps; // step_lock_toggle state
		logic lock_en; // lock feature enabled
		logic cw; // cw demodulation
		logic ptt; // push to talk
	} vst_ctrl_s;
	typedef struct packed {
		logic click; // apply armed direction
		logic arm_dn; // lower half clicked
		logic arm_up; // upper half clicked
		logic shift; // quintuple_step for this step
		logic down; // one step down
		logic up; // one step up
		logic right; // finer decade
		logic left; // coarser decade
		logic equal; // equalise
		logic redo; // redo zeroing
		logic undo; // undo zeroing
		logic zero; // zero fine offset
		logic sel; // toggle tuned setting
		logic split; // toggle simplex/split
	} vst_cmd_s;
	typedef enum logic {RP_IDLE = 1'b0, RP_RUN = 1'b1} vst_rpt_e;
endpackage

// [hw/vst_top.sv]
// oscillator split, fine offset and tuning control with apb registers
// Overview of operation
// - simplex transmits on receive; split keeps both
// - toggle command flips simplex and split
// - cw mode change shifts receive by offset
// - fine offset moves receive only, both modes
// - fine offset clamped to plus/minus 10 kHz
// - zero pushes offset; undo, redo over ten
// - split receive tuning leaves transmit alone
// - in split, select toggles tuning and listening to transmit
// - ptt release in split returns to receive
// - split to simplex copies receive into transmit
// - equalise copies active setting to both
// - left/right move decade; up/down step it
// - upper/lower click arms; next click applies
// - held input repeats at 20 steps per second
// - low decades ramp to 200/s over 10 s
// - shift or locked caps gives five-times step
// - repeat rate independent of keyboard settings
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module vst_top import vst_pkg::*; #(
	parameter int RAMP_CYCLES = RAMP_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// frequency outputs
	output logic [31:0] listen_freq_o,
	output logic [31:0] tx_freq_o,
	output logic quint_ind_o
);
	// ****************************************
	// helpers
	// ****************************************
	// saturating add or subtract of a step
	function automatic logic [31:0] add_sat(input logic [31:0] f, input logic [31:0] d,
		input logic dn);
		logic [32:0] s;
		s = {1'b0, f} + {1'b0, d};
		if (dn) return (f > d) ? f - d : 32'h0000_0000;
		return s[32] ? 32'hffff_ffff : s[31:0];
	endfunction
	// step size of a decade, optionally times five
	function automatic logic [31:0] step_of(input logic [2:0] dec, input logic q);
		logic [31:0] p;
		case (dec)
			3'h0: p = 32'h0000_0001;
			3'h1: p = 32'h0000_000a;
			3'h2: p = 32'h0000_0064;
			3'h3: p = 32'h0000_03e8;
			3'h4: p = 32'h0000_2710;
			3'h5: p = 32'h0001_86a0;
			3'h6: p = 32'h000f_4240;
			default: p = 32'h0098_9680;
		endcase
		return q ? (p << 2) + p : p;
	endfunction
	// clamp a written fine offset
	function automatic logic signed [15:0] clamp_fine(input logic [31:0] v);
		if ($signed(v) > 32'(FINE_MAX)) return FINE_MAX;
		if ($signed(v) < 32'(FINE_MIN)) return FINE_MIN;
		return v[15:0];
	endfunction
	// ****************************************
	// state
	// ****************************************
	vst_ctrl_s ctrl_r; // level controls
	logic split_r; // split mode
	logic tune_tx_r; // transmit setting tuned and heard
	logic [31:0] rx_r, rx_nxt; // receive setting
	logic [31:0] tx_r, tx_nxt; // transmit setting
	logic [31:0] cwoff_r; // cw shift amount
	logic [2:0] dec_rx_r, dec_tx_r; // decade per setting
	logic arm_v_r, arm_dn_r; // armed pointer direction
	logic signed [15:0] fine_r; // receive fine offset
	logic signed [15:0] hist_r [10]; // undo history
	logic [3:0] wptr_r, cnt_r, redo_r; // history pointers
	vst_rpt_e rp_r; // repeat state
	logic [25:0] acc_r; // rate accumulator
	logic [7:0] rate_r; // current steps per second
	logic [22:0] ramp_r; // acceleration timer
	// ****************************************
	// apb decode
	// ****************************************
	wire acc_ev = psel & penable & pready; // transfer completes
	wire wr_ev = acc_ev & pwrite; // write lands
	wire mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0); // eight words
	wire wr_ctrl = wr_ev && paddr == OFF_CTRL; // control write
	wire wr_rx = wr_ev && paddr == OFF_RXF; // receive write
	wire wr_tx = wr_ev && paddr == OFF_TXF; // transmit write
	wire wr_fine = wr_ev && paddr == OFF_FINE; // offset write
	wire wr_cw = wr_ev && paddr == OFF_CWOFF; // cw amount write
	wire vst_cmd_s c = (wr_ev && paddr == OFF_CMD) ? vst_cmd_s'(pwdata[CMD_W-1:0]) : '0;
	wire vst_ctrl_s ctrl_nx = wr_ctrl ? vst_ctrl_s'(pwdata[CTRL_W-1:0]) : ctrl_r;
	// ****************************************
	// mode and selection
	// ****************************************
	wire split_nxt = split_r ^ c.split;
	wire ptt_fall = ctrl_r.ptt & ~ctrl_nx.ptt; // push to talk released
	// transmit tuning only exists in split; release or select returns to receive
	wire tune_nxt = split_nxt & ~(split_r & tune_tx_r & ptt_fall) & (tune_tx_r ^ c.sel);
	wire tune_sel = split_r & tune_tx_r; // tuning the transmit setting
	wire [2:0] dec_cur = tune_sel ? dec_tx_r : dec_rx_r;
	wire lock_q = ctrl_r.lock_en & ctrl_r.caps; // locked five-times stepping
	// ****************************************
	// step events
	// ****************************************
	wire held = ctrl_r.hold_up | ctrl_r.hold_dn; // tuning input held
	wire [25:0] acc_sum = acc_r + 26'(rate_r); // accumulate rate
	wire rpt_tick = (rp_r == RP_RUN) & held & (acc_sum >= 26'(CLK_HZ));
	wire rpt_first = (rp_r == RP_IDLE) & held; // immediate first step
	wire click_go = c.click & arm_v_r;
	wire step_ev = c.up | c.down | click_go | rpt_tick | rpt_first;
	wire step_dn = c.down | (click_go & arm_dn_r) | ((rpt_tick | rpt_first) & ctrl_r.hold_dn);
	wire [31:0] step_amt = step_of(dec_cur, c.shift | lock_q);
	wire cw_chg = wr_ctrl & (ctrl_nx.cw != ctrl_r.cw); // cw mode entered or left
	wire eq_ev = c.equal & split_r;
	wire [31:0] active_f = tune_sel ? tx_r : rx_r; // setting active now
	// ****************************************
	// frequency update
	// ****************************************
	// one ordered update per cycle keeps both settings coherent
	always_comb begin
		rx_nxt = wr_rx ? pwdata : rx_r;
		tx_nxt = wr_tx ? pwdata : tx_r;
		if (cw_chg) begin
			rx_nxt = add_sat(rx_r, cwoff_r, ~ctrl_nx.cw);
		end
		if (step_ev && tune_sel) begin
			tx_nxt = add_sat(tx_r, step_amt, step_dn);
		end else if (step_ev) begin
			rx_nxt = add_sat(rx_r, step_amt, step_dn);
		end
		if (eq_ev) begin
			rx_nxt = active_f;
			tx_nxt = active_f;
		end
		if (!split_nxt) begin
			tx_nxt = rx_nxt;
		end
	end
	// ****************************************
	// control registers
	// ****************************************
	// modes, control levels, settings and cw shift amount
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= '0;
			split_r <= 1'b0;
			tune_tx_r <= 1'b0;
			rx_r <= 32'h0000_0000;
			tx_r <= 32'h0000_0000;
			cwoff_r <= CWOFF_RST;
		end else begin
			ctrl_r <= ctrl_nx;
			split_r <= split_nxt;
			tune_tx_r <= tune_nxt;
			rx_r <= rx_nxt;
			tx_r <= tx_nxt;
			cwoff_r <= wr_cw ? pwdata : cwoff_r;
		end
	end
	// left is the coarser digit, right the finer; clamped at both ends
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dec_rx_r <= 3'h0;
			dec_tx_r <= 3'h0;
			arm_v_r <= 1'b0;
			arm_dn_r <= 1'b0;
		end else begin
			if (tune_sel && c.left && dec_tx_r != DEC_TOP) dec_tx_r <= dec_tx_r + 3'h1;
			if (tune_sel && c.right && dec_tx_r != 3'h0) dec_tx_r <= dec_tx_r - 3'h1;
			if (!tune_sel && c.left && dec_rx_r != DEC_TOP) dec_rx_r <= dec_rx_r + 3'h1;
			if (!tune_sel && c.right && dec_rx_r != 3'h0) dec_rx_r <= dec_rx_r - 3'h1;
			if (c.arm_up | c.arm_dn) begin
				arm_v_r <= 1'b1;
				arm_dn_r <= c.arm_dn;
			end
		end
	end
	// ****************************************
	// auto-repeat with acceleration
	// ****************************************
	// low decades gain one step/s per ramp period up to the top rate
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rp_r <= RP_IDLE;
			acc_r <= 26'h0;
			rate_r <= RPT_HZ;
			ramp_r <= 23'h0;
		end else if (!held) begin
			rp_r <= RP_IDLE;
			acc_r <= 26'h0;
			rate_r <= RPT_HZ;
			ramp_r <= 23'h0;
		end else begin
			rp_r <= RP_RUN;
			acc_r <= rpt_tick ? acc_sum - 26'(CLK_HZ) : (rpt_first ? 26'h0 : acc_sum);
			if (dec_cur < 3'h2 && rate_r < ACC_HZ) begin
				ramp_r <= (ramp_r == 23'(RAMP_CYCLES - 1)) ? 23'h0 : ramp_r + 23'h1;
				if (ramp_r == 23'(RAMP_CYCLES - 1)) rate_r <= rate_r + 8'h01;
			end
		end
	end
	// ****************************************
	// fine offset and history
	// ****************************************
	wire [3:0] wptr_inc = (wptr_r == HIST_DEPTH - 4'h1) ? 4'h0 : wptr_r + 4'h1; // push slot
	wire [3:0] wptr_dec = (wptr_r == 4'h0) ? HIST_DEPTH - 4'h1 : wptr_r - 4'h1; // pop slot
	wire do_undo = c.undo & ~c.zero & (cnt_r != 4'h0); // restore previous
	wire do_redo = c.redo & ~c.zero & ~c.undo & (redo_r != 4'h0); // zero again
	// oldest entry is overwritten once ten are stored
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fine_r <= 16'sh0000;
			wptr_r <= 4'h0;
			cnt_r <= 4'h0;
			redo_r <= 4'h0;
		end else if (c.zero | do_redo) begin
			fine_r <= 16'sh0000;
			wptr_r <= wptr_inc;
			cnt_r <= (cnt_r == HIST_DEPTH) ? cnt_r : cnt_r + 4'h1;
			redo_r <= c.zero ? 4'h0 : redo_r - 4'h1;
		end else if (do_undo) begin
			fine_r <= hist_r[wptr_dec];
			wptr_r <= wptr_dec;
			cnt_r <= cnt_r - 4'h1;
			redo_r <= redo_r + 4'h1;
		end else if (wr_fine) begin
			fine_r <= clamp_fine(pwdata);
			redo_r <= 4'h0;
		end
	end
	// history storage, no reset needed
	always_ff @(posedge core_clk) begin
		if (c.zero | do_redo) hist_r[wptr_r] <= fine_r;
	end
	// ****************************************
	// outputs and read data
	// ****************************************
	wire hear_tx = tune_sel & ~ctrl_r.ptt;
	wire [32:0] heard = {1'b0, rx_r} + {{17{fine_r[15]}}, fine_r};
	// negative offset: bit 32 set means the sum dropped below zero
	wire [31:0] rx_heard = (fine_r < 0) ? (heard[32] ? 32'h0000_0000 : heard[31:0]) :
		(heard[32] ? 32'hffff_ffff : heard[31:0]);
	wire [31:0] stat = {16'h0, cnt_r, redo_r, lock_q, arm_dn_r, arm_v_r, dec_cur, tune_sel, split_r};
	wire [31:0] rd_mux = (paddr == OFF_CTRL) ? {26'h0, ctrl_r} :
		(paddr == OFF_RXF) ? rx_r : (paddr == OFF_TXF) ? tx_r :
		(paddr == OFF_FINE) ? {{16{fine_r[15]}}, fine_r} :
		(paddr == OFF_CWOFF) ? cwoff_r : (paddr == OFF_STAT) ? stat :
		(paddr == OFF_LISTEN) ? listen_freq_o : 32'h0000_0000;
	// one wait state: ready rises in the second access cycle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			listen_freq_o <= 32'h0000_0000;
			tx_freq_o <= 32'h0000_0000;
			quint_ind_o <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			prdata <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
			listen_freq_o <= hear_tx ? tx_r : rx_heard;
			tx_freq_o <= split_r ? tx_r : rx_r;
			quint_ind_o <= lock_q;
		end
	end
	// ****************************************
	// checks
	// ****************************************
	a_simplex_tx_same: assert property (@(posedge core_clk) disable iff (!rst_b)
		!split_r |-> tx_r == rx_r) else $error("simplex transmit differs");
	a_split_flip: assert property (@(posedge core_clk) disable iff (!rst_b)
		c.split |=> split_r != $past(split_r)) else $error("split toggle lost");
	a_cw_shift: assert property (@(posedge core_clk) disable iff (!rst_b)
		cw_chg && !step_ev && !eq_ev && !wr_rx |=>
		rx_r == add_sat($past(rx_r), $past(cwoff_r), !ctrl_r.cw)) else $error("cw shift");
	a_fine_range: assert property (@(posedge core_clk) disable iff (!rst_b)
		fine_r <= FINE_MAX && fine_r >= FINE_MIN) else $error("fine offset out of range");
	a_zero_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		c.zero |=> fine_r == 0 && redo_r == 0) else $error("zero failed");
	a_tx_kept: assert property (@(posedge core_clk) disable iff (!rst_b)
		split_r && split_nxt && !tune_sel && !wr_tx && !eq_ev |=> $stable(tx_r))
		else $error("transmit moved");
	a_ptt_return: assert property (@(posedge core_clk) disable iff (!rst_b)
		tune_sel && ptt_fall |=> !tune_tx_r ##1 listen_freq_o == $past(rx_heard))
		else $error("no return to receive");
	a_step_floor: assert property (@(posedge core_clk) disable iff (!rst_b)
		c.down && !tune_sel && rx_r < step_amt && !eq_ev && !cw_chg && !wr_rx |=> rx_r == 0)
		else $error("step wrapped");
	a_rate_range: assert property (@(posedge core_clk) disable iff (!rst_b)
		rate_r >= RPT_HZ && rate_r <= ACC_HZ) else $error("repeat rate out of range");
endmodule
`default_nettype wire

// [sim/tb_vst_top.sv]
// self-checking bench for the split and tuning control
`timescale 1ns/1ps
`default_nettype none
module tb_vst_top import vst_pkg::*;;
	localparam logic [31:0] F1M = 32'h000f_4240; // 1 MHz
	localparam logic [31:0] F2M = 32'h001e_8480; // 2 MHz
	localparam logic [31:0] F3M = 32'h002d_c6c0; // 3 MHz
	logic core_clk = 1'b0; // 40 MHz clock
	logic rst_b = 1'b0; // reset, active low
	logic psel, penable, pwrite, pready, pslverr, quint_ind_o;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, listen_freq_o, tx_freq_o;
	int failures = 0;
	int n_compared = 0;
	always #12.5 core_clk = ~core_clk;
	vst_top #(.RAMP_CYCLES(4)) vst_top_inst (.core_clk(core_clk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.listen_freq_o(listen_freq_o), .tx_freq_o(tx_freq_o),
		.quint_ind_o(quint_ind_o));
	vst_operator vst_operator_inst (.core_clk(core_clk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	// verdict and end of run
	task automatic stop_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// one value against its expectation
	task automatic chk(input logic [31:0] got, input logic [31:0] x, input string m);
		n_compared++;
		if (got !== x) begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, x);
		end
	endtask
	// bus transfer, stops the run if unanswered
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		vst_operator_inst.xfer(w, a, d, q, e);
		if (vst_operator_inst.lost != 0) begin
			failures++;
			$display("unexpected at %0t: no answer", $time);
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xf(1'b1, a, d, q, e);
	endtask
	// masked register read compare
	task automatic chkm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		xf(1'b0, a, 32'h0000_0000, q, e);
		chk(q & m, x, "read");
	endtask
	task automatic chkr(input logic [7:0] a, input logic [31:0] x);
		chkm(a, 32'hffff_ffff, x);
	endtask
	// frequency outputs once settled
	task automatic chko(input logic [31:0] l, input logic [31:0] t);
		repeat (3) @(posedge core_clk);
		chk(listen_freq_o, l, "listen");
		chk(tx_freq_o, t, "tx");
	endtask
	// main sequence
	initial begin
		logic [31:0] q;
		logic e;
		int i;
		@(posedge core_clk);
		chko(32'h0, 32'h0);
		rst_b <= 1'b1;
		chkr(OFF_CWOFF, CWOFF_RST);
		chkm(OFF_STAT, 32'h1f, 32'h0);
		xf(1'b0, 8'h20, 32'h0, q, e);
		chk({31'h0, e}, 32'h1, "unmapped");
		xf(1'b0, 8'h06, 32'h0, q, e);
		chk({31'h0, e}, 32'h1, "unaligned");
		$display("test reset done");
		wr(OFF_RXF, F1M);
		wr(OFF_TXF, 32'h5);
		chko(F1M, F1M);
		wr(OFF_CMD, 32'h1);
		chkm(OFF_STAT, 32'h3, 32'h1);
		wr(OFF_TXF, F2M);
		wr(OFF_CMD, 32'h100);
		chko(F1M + 32'h1, F2M);
		wr(OFF_CMD, 32'h2);
		chko(F2M, F2M);
		wr(OFF_CMD, 32'h2);
		chko(F1M + 32'h1, F2M);
		wr(OFF_CMD, 32'h2);
		wr(OFF_CMD, 32'h20);
		chkr(OFF_RXF, F2M);
		wr(OFF_TXF, F3M);
		wr(OFF_CTRL, 32'h1);
		wr(OFF_CTRL, 32'h0);
		chko(F2M, F3M);
		wr(OFF_CMD, 32'h1);
		chko(F2M, F2M);
		$display("test split done");
		wr(OFF_FINE, 32'h4e20);
		chkr(OFF_FINE, 32'h2710);
		chko(F2M + 32'h2710, F2M);
		wr(OFF_FINE, 32'hffff_fed4);
		chkr(OFF_FINE, 32'hffff_fed4);
		chko(F2M - 32'h12c, F2M);
		chkr(OFF_LISTEN, F2M - 32'h12c);
		for (i = 1; i <= 11; i++) begin
			wr(OFF_FINE, 32'(i));
			wr(OFF_CMD, 32'h4);
		end
		chkr(OFF_FINE, 32'h0);
		for (i = 11; i >= 2; i--) begin
			wr(OFF_CMD, 32'h8);
			chkr(OFF_FINE, 32'(i));
		end
		wr(OFF_CMD, 32'h10);
		chkr(OFF_FINE, 32'h0);
		$display("test offset done");
		wr(OFF_CMD, 32'h40);
		wr(OFF_CMD, 32'h40);
		chkm(OFF_STAT, 32'h1c, 32'h8);
		wr(OFF_CMD, 32'h100);
		chkr(OFF_RXF, F2M + 32'h64);
		wr(OFF_CMD, 32'h600);
		chkr(OFF_RXF, F2M - 32'h190);
		wr(OFF_CTRL, 32'hc);
		chko(F2M - 32'h190, F2M - 32'h190);
		chk({31'h0, quint_ind_o}, 32'h1, "quint");
		wr(OFF_CMD, 32'h100);
		chkr(OFF_RXF, F2M + 32'h64);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CMD, 32'h1000);
		wr(OFF_CMD, 32'h2000);
		chkr(OFF_RXF, F2M);
		wr(OFF_CMD, 32'h2000);
		chkr(OFF_RXF, F2M - 32'h64);
		wr(OFF_CMD, 32'h80);
		chkm(OFF_STAT, 32'h1c, 32'h4);
		wr(OFF_RXF, 32'h5);
		wr(OFF_CMD, 32'h200);
		chkr(OFF_RXF, 32'h0);
		wr(OFF_CMD, 32'h1);
		wr(OFF_CMD, 32'h2);
		chkm(OFF_STAT, 32'h1f, 32'h3);
		wr(OFF_CMD, 32'h1);
		$display("test tuning done");
		wr(OFF_RXF, F2M);
		wr(OFF_CWOFF, 32'h2bc);
		wr(OFF_CTRL, 32'h2);
		chkr(OFF_RXF, F2M + 32'h2bc);
		wr(OFF_CTRL, 32'h0);
		chkr(OFF_RXF, F2M);
		$display("test cw done");
		wr(OFF_CTRL, 32'h10);
		wr(OFF_CTRL, 32'h0);
		chkr(OFF_RXF, F2M + 32'ha);
		wr(OFF_CTRL, 32'h20);
		wr(OFF_CTRL, 32'h0);
		chkr(OFF_RXF, F2M);
		wr(OFF_CMD, 32'h800);
		wr(OFF_CMD, 32'h2000);
		chkr(OFF_RXF, F2M + 32'ha);
		$display("test hold done");
		stop_test();
	end
endmodule
`default_nettype wire

// [sim/vst_operator.sv]
// operator model: apb master carrying operator commands
`timescale 1ns/1ps
`default_nettype none
module vst_operator import vst_pkg::*; (
	// clock
	input wire logic core_clk,
	// apb request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	// apb answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	int lost = 0; // transfers never answered
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// one transfer, held until pready is sampled high or 16 cycles pass
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (n == 16) lost++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // released data stops showing the word
	endtask
endmodule
`default_nettype wire
